/* include/ppc_pkg.sv */
package ppc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PADCFG_BASE_OFS = 8'h10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_FREEZE_BIT = 0;
    localparam int CTRL_CFG_DONE_BIT = 1;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_FLOAT_BIT = 1;
    localparam int STAT_FREEZE_BIT = 2;
    localparam int STAT_PAD_LSB = 8;

    // ------------------------------------------------------------------
    // Per-pad configuration word fields
    // ------------------------------------------------------------------
    localparam int PCFG_USED_BIT = 0;
    localparam int PCFG_IN_REG_BIT = 1;
    localparam int PCFG_OUT_REG_BIT = 2;
    localparam int PCFG_OE_REG_BIT = 3;
    localparam int PCFG_FREEZE_EN_BIT = 4;
    localparam int PCFG_PULL_EN_BIT = 5;
    localparam int PCFG_PULL_SEL_LSB = 6;
    localparam int PCFG_OUT_SEL_BIT = 8;
    localparam int PCFG_W = 9;

    // ------------------------------------------------------------------
    // Pull-up strength choices, weakest is the default
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PULL_3K3 = 2'h0,
        PULL_6K8 = 2'h1,
        PULL_10K = 2'h2,
        PULL_100K = 2'h3
    } ppc_pull_t;

    typedef struct packed
    {
        logic out_sel;
        ppc_pull_t pull_sel;
        logic pull_en;
        logic freeze_en;
        logic oe_reg;
        logic out_reg;
        logic in_reg;
        logic used;
    } ppc_padcfg_t;

    localparam ppc_padcfg_t PADCFG_RST = '{
        out_sel: 1'b0, pull_sel: PULL_100K, pull_en: 1'b1,
        freeze_en: 1'b0, oe_reg: 1'b0, out_reg: 1'b0,
        in_reg: 1'b0, used: 1'b0};

    // ------------------------------------------------------------------
    // Configuration phase
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PH_POR = 2'b00,
        PH_LOAD = 2'b01,
        PH_RUN = 2'b11
    } ppc_phase_t;

endpackage

/* rtl/ppc_pad_slice.sv */
`timescale 1ns/1ps
module ppc_pad_slice
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic active_in,
    input wire ppc_pkg::ppc_padcfg_t cfg_in,
    input wire logic freeze_in,
    input wire logic in_tick_in,
    input wire logic out_tick_in,
    input wire logic ce_in,
    input wire logic oe_in,
    input wire logic hold_in,
    input wire logic [1:0] dout_in,
    output logic [1:0] din_out,
    input wire logic pad_i_in,
    output logic pad_o_out,
    output logic pad_oe_b_out,
    output logic pull_en_out,
    output ppc_pkg::ppc_pull_t pull_sel_out,
    output logic in_block_out
);

    typedef struct packed
    {
        logic [1:0] in_q;
        logic [1:0] out_q;
        logic oe_q;
        logic [1:0] keep_q;
    } ppc_slice_t;

    ppc_slice_t s_q;
    ppc_slice_t s_d;
    logic [1:0] live;
    logic frozen;
    logic used_act;
    logic drive_dat;
    logic drive_oe;

    // ------------------------------------------------------------------
    // Register stages
    // ------------------------------------------------------------------
    always_comb
    begin
        live = cfg_in.in_reg ? s_q.in_q : {pad_i_in, pad_i_in};
        frozen = freeze_in && cfg_in.freeze_en && !cfg_in.in_reg;
        s_d = s_q;
        if (!active_in)
        begin
            s_d = '0;
        end
        else
        begin
            if (in_tick_in && ce_in)
            begin
                s_d.in_q = {s_q.in_q[0], pad_i_in};
            end
            if (out_tick_in && ce_in)
            begin
                s_d.out_q = dout_in;
                s_d.oe_q = oe_in;
            end
            // Keeper tracks the live value and stops once held or frozen
            if (!(hold_in || frozen))
            begin
                s_d.keep_q = live;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Pad and core outputs
    // ------------------------------------------------------------------
    always_comb
    begin
        used_act = active_in && cfg_in.used;
        drive_dat = cfg_in.out_reg ? s_q.out_q[cfg_in.out_sel]
                                   : dout_in[cfg_in.out_sel];
        drive_oe = cfg_in.oe_reg ? s_q.oe_q : oe_in;
        pad_o_out = used_act && drive_dat;
        pad_oe_b_out = !(used_act && drive_oe);
        in_block_out = active_in && !cfg_in.used;
        pull_en_out = !active_in || (cfg_in.used && cfg_in.pull_en);
        pull_sel_out = active_in ? cfg_in.pull_sel
                                 : ppc_pkg::PULL_100K;
        if (!used_act)
        begin
            din_out = 2'h0;
        end
        else if (hold_in || frozen)
        begin
            din_out = s_q.keep_q;
        end
        else
        begin
            din_out = live;
        end
    end

endmodule // ppc_pad_slice

/* rtl/ppc_pad_bank.sv */
`timescale 1ns/1ps
// What this block does
// - Each cell has input, output and enable register stages with modes.
// - Inbound register, stepped by input tick, samples pad before the core.
// - Outbound data goes straight to the pad or through the output register.
// - Bank freeze holds unregistered inputs of cells that opted in.
// - Registered inputs hold whenever their tick or clock enable is absent.
// - Hold input latches the inbound value and presents it until released.
// - Until reset ends and configuration completes, pads float, weak pull-up.
// - User pad settings apply only after reset release and configuration.
// - After configuration, unused pads have input blocked and pull-up off.
// - Each pad selects pull-up or none, strength from four, weakest default.
// - Global float forces all pad outputs off throughout configuration.
// - Global reset keeps every cell flip-flop cleared during configuration.
module ppc_pad_bank
#(
    parameter int N_PADS = 4
)
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [ppc_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [ppc_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [ppc_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic [N_PADS-1:0] in_tick_in,
    input wire logic [N_PADS-1:0] out_tick_in,
    input wire logic [N_PADS-1:0] ce_in,
    input wire logic [N_PADS-1:0] oe_in,
    input wire logic [N_PADS-1:0] hold_in,
    input wire logic [N_PADS-1:0] dout0_in,
    input wire logic [N_PADS-1:0] dout1_in,
    output logic [N_PADS-1:0] din0_out,
    output logic [N_PADS-1:0] din1_out,
    input wire logic [N_PADS-1:0] pad_i_in,
    output logic [N_PADS-1:0] pad_o_out,
    output logic [N_PADS-1:0] pad_oe_b_out,
    output logic [N_PADS-1:0] pull_en_out,
    output logic [2*N_PADS-1:0] pull_sel_out,
    output logic [N_PADS-1:0] in_block_out,
    output logic active_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed
    {
        ppc_pkg::ppc_phase_t phase_q;
        logic freeze_q;
        logic cfg_done_q;
        ppc_pkg::ppc_padcfg_t [N_PADS-1:0] cfg_q;
        logic [ppc_pkg::DATA_W-1:0] rdata_q;
    } ppc_bank_t;

    ppc_bank_t s_q;
    ppc_bank_t s_d;
    logic active;
    logic [N_PADS-1:0] din0;

    // Word index of a pad configuration slot, or N_PADS when not one
    function automatic int pad_index(input logic [ppc_pkg::ADDR_W-1:0] a);
        int idx;
        idx = N_PADS;
        for (int i = 0; i < N_PADS; i++)
        begin
            if (a == ppc_pkg::PADCFG_BASE_OFS + ppc_pkg::ADDR_W'(4 * i))
            begin
                idx = i;
            end
        end
        return idx;
    endfunction

    function automatic logic [ppc_pkg::DATA_W-1:0] read_word(
        input logic [ppc_pkg::ADDR_W-1:0] a,
        input ppc_bank_t s,
        input logic [N_PADS-1:0] lvl);
        logic [ppc_pkg::DATA_W-1:0] w;
        int idx;
        w = '0;
        idx = pad_index(a);
        if (a == ppc_pkg::CTRL_OFS)
        begin
            w[ppc_pkg::CTRL_FREEZE_BIT] = s.freeze_q;
            w[ppc_pkg::CTRL_CFG_DONE_BIT] = s.cfg_done_q;
        end
        else if (a == ppc_pkg::STATUS_OFS)
        begin
            w[ppc_pkg::STAT_ACTIVE_BIT] = (s.phase_q == ppc_pkg::PH_RUN);
            w[ppc_pkg::STAT_FLOAT_BIT] = (s.phase_q != ppc_pkg::PH_RUN);
            w[ppc_pkg::STAT_FREEZE_BIT] = s.freeze_q;
            w[ppc_pkg::STAT_PAD_LSB +: N_PADS] = lvl;
        end
        else if (idx < N_PADS)
        begin
            w[ppc_pkg::PCFG_W-1:0] = s.cfg_q[idx];
        end
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Register port and configuration phase
    // ------------------------------------------------------------------
    always_comb
    begin
        int widx;
        widx = pad_index(reg_addr_in);
        s_d = s_q;
        s_d.rdata_q = '0;
        if (reg_rd_in)
        begin
            s_d.rdata_q = read_word(reg_addr_in, s_q, din0);
        end
        if (reg_wr_in)
        begin
            if (reg_addr_in == ppc_pkg::CTRL_OFS)
            begin
                s_d.freeze_q = reg_wdata_in[ppc_pkg::CTRL_FREEZE_BIT];
                s_d.cfg_done_q = reg_wdata_in[ppc_pkg::CTRL_CFG_DONE_BIT];
            end
            else if (widx < N_PADS)
            begin
                s_d.cfg_q[widx] = reg_wdata_in[ppc_pkg::PCFG_W-1:0];
            end
        end
        unique case (s_q.phase_q)
            ppc_pkg::PH_POR:
            begin
                s_d.phase_q = ppc_pkg::PH_LOAD;
            end
            ppc_pkg::PH_LOAD:
            begin
                if (s_q.cfg_done_q)
                begin
                    s_d.phase_q = ppc_pkg::PH_RUN;
                end
            end
            ppc_pkg::PH_RUN:
            begin
                // Clearing the done bit starts a fresh download
                if (!s_q.cfg_done_q)
                begin
                    s_d.phase_q = ppc_pkg::PH_LOAD;
                end
            end
            default:
            begin
                s_d.phase_q = ppc_pkg::PH_POR;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s_q.phase_q <= ppc_pkg::PH_POR;
            s_q.freeze_q <= 1'b0;
            s_q.cfg_done_q <= 1'b0;
            s_q.cfg_q <= {N_PADS{ppc_pkg::PADCFG_RST}};
            s_q.rdata_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Only a finished download after reset lets the user settings through
    assign active = (s_q.phase_q == ppc_pkg::PH_RUN);
    assign active_out = active;
    assign reg_rdata_out = s_q.rdata_q;
    assign din0_out = din0;

    // ------------------------------------------------------------------
    // Pad cells
    // ------------------------------------------------------------------
    for (genvar g = 0; g < N_PADS; g++)
    begin : g_pad
        logic [1:0] din;
        ppc_pkg::ppc_pull_t psel;

        ppc_pad_slice u_slice
        (
            .sys_clk_in(sys_clk_in),
            .rst_b_in(rst_b_in),
            .active_in(active),
            .cfg_in(s_q.cfg_q[g]),
            .freeze_in(s_q.freeze_q),
            .in_tick_in(in_tick_in[g]),
            .out_tick_in(out_tick_in[g]),
            .ce_in(ce_in[g]),
            .oe_in(oe_in[g]),
            .hold_in(hold_in[g]),
            .dout_in({dout1_in[g], dout0_in[g]}),
            .din_out(din),
            .pad_i_in(pad_i_in[g]),
            .pad_o_out(pad_o_out[g]),
            .pad_oe_b_out(pad_oe_b_out[g]),
            .pull_en_out(pull_en_out[g]),
            .pull_sel_out(psel),
            .in_block_out(in_block_out[g])
        );

        assign din0[g] = din[0];
        assign din1_out[g] = din[1];
        assign pull_sel_out[2*g +: 2] = psel;
    end

endmodule // ppc_pad_bank

/* verif/ppc_bank_sva.sv */
`timescale 1ns/1ps
module ppc_bank_sva
#(
    parameter int N_PADS = 4
)
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [ppc_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic [N_PADS-1:0] ce_in,
    input wire logic [N_PADS-1:0] hold_in,
    input wire logic [N_PADS-1:0] din0_out,
    input wire logic [N_PADS-1:0] pad_i_in,
    input wire logic [N_PADS-1:0] pad_oe_b_out,
    input wire logic [N_PADS-1:0] pull_en_out,
    input wire logic [2*N_PADS-1:0] pull_sel_out,
    input wire logic [N_PADS-1:0] in_block_out,
    input wire logic active_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // ------------------------------------------------------------
    // Pad state while not running
    // ------------------------------------------------------------
    float_cfg_a: assert property (!active_out |-> &pad_oe_b_out)
        else $error("pad driven before configuration");
    pull_cfg_a: assert property (
        !active_out |-> &pull_en_out && &pull_sel_out)
        else $error("weak pull-up missing before configuration");
    din_clr_a: assert property (!active_out |-> din0_out == '0)
        else $error("inbound data not cleared");

    // ------------------------------------------------------------
    // Entry to and exit from the running phase, and unused pads
    // ------------------------------------------------------------
    act_rise_a: assert property (
        $rose(active_out) |-> $past(reg_wr_in, 2)
            && $past(reg_wdata_in[1], 2))
        else $error("active without configuration done");
    act_fall_a: assert property (
        $fell(active_out) |-> $past(reg_wr_in, 2)
            && !$past(reg_wdata_in[1], 2))
        else $error("active dropped without a write");
    unused_pad_a: assert property (
        (in_block_out & (pull_en_out | ~pad_oe_b_out | din0_out)) == '0)
        else $error("blocked pad not quiet");

    // ------------------------------------------------------------
    // Inbound holding
    // ------------------------------------------------------------
    // Config writes excluded: they may legally change the mode
    hold_keep_a: assert property (
        active_out && $past(active_out) && hold_in[0] && $past(hold_in[0])
            && !$past(reg_wr_in) |-> $stable(din0_out[0]))
        else $error("held input moved");
    reg_in_a: assert property (
        active_out && $past(active_out) && !$past(ce_in[1])
            && !$past(reg_wr_in) && $stable(pad_i_in[1])
            && $stable(hold_in[1]) |-> $stable(din0_out[1]))
        else $error("input moved with clock enable low");

    cover property (hold_in[0] && active_out);
    cover property ($rose(active_out));
    cover property ($fell(active_out));
endmodule // ppc_bank_sva

/* verif/ppc_pad_ext.sv */
`timescale 1ns/1ps
module ppc_pad_ext
#(
    parameter int N = 4
)
(
    input wire logic sys_clk_in,
    input wire logic [N-1:0] pad_o_in,
    input wire logic [N-1:0] pad_oe_b_in,
    input wire logic [N-1:0] pull_en_in,
    input wire logic [N-1:0] drv_in,
    input wire logic [N-1:0] lvl_in,
    output logic [N-1:0] pad_i_out
);
    logic [N-1:0] last_q;

    // Floating, unpulled pads show the inverse of their last level,
    // so a stale value can never pass for a live one
    always_comb
    begin
        for (int g = 0; g < N; g++)
        begin
            if (!pad_oe_b_in[g])
                pad_i_out[g] = pad_o_in[g];
            else if (drv_in[g])
                pad_i_out[g] = lvl_in[g];
            else if (pull_en_in[g])
                pad_i_out[g] = 1'b1;
            else
                pad_i_out[g] = ~last_q[g];
        end
    end

    always_ff @(posedge sys_clk_in)
        last_q <= pad_i_out;
endmodule // ppc_pad_ext

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_b, wr, rd, act;
    logic [7:0] addr, psel;
    logic [31:0] wdata, rdata;
    logic [3:0] itk, otk, ce, oe, hold, do0, do1, d0, d1;
    logic [3:0] pi, po, oeb, pen, blk, drv, lvl;
    int n_mismatch, n_tests;

    ppc_pad_bank #(.N_PADS(4)) u_dut (
        .sys_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .in_tick_in(itk), .out_tick_in(otk),
        .ce_in(ce), .oe_in(oe), .hold_in(hold), .dout0_in(do0),
        .dout1_in(do1), .din0_out(d0), .din1_out(d1), .pad_i_in(pi),
        .pad_o_out(po), .pad_oe_b_out(oeb), .pull_en_out(pen),
        .pull_sel_out(psel), .in_block_out(blk), .active_out(act));

    ppc_pad_ext #(.N(4)) u_ext (
        .sys_clk_in(clk), .pad_o_in(po), .pad_oe_b_in(oeb),
        .pull_en_in(pen), .drv_in(drv), .lvl_in(lvl), .pad_i_out(pi));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #2;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #2;
        chk("rdata", rdata, e);
    endtask

    task automatic tick_o();
        @(posedge clk);
        otk <= 4'h2;
        @(posedge clk);
        otk <= 4'h0;
        #2;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_pre();
        int i;
        rd_reg(8'h10, 32'h0e0);
        rd_reg(8'h04, 32'h002);
        rd_reg(8'h40, 32'h000);
        wr_reg(8'h10, 32'h001);
        wr_reg(8'h14, 32'h10f);
        wr_reg(8'h18, 32'h071);
        @(posedge clk);
        oe <= 4'hf;
        #2;
        chk("oeb", 32'(oeb), 32'hf);
        chk("pull", 32'({pen, psel}), 32'hfff);
        chk("din", 32'(d0), 32'h0);
        @(posedge clk);
        oe <= 4'h0;
        wr_reg(8'h00, 32'h002);
        for (i = 0; i < 5 && act !== 1'b1; i++)
        begin
            @(posedge clk);
            #2;
        end
        chk("act", 32'(act), 32'h1);
        if (act !== 1'b1)
            finish_test();
        $display("t_pre done");
    endtask

    task automatic t_out();
        @(posedge clk);
        oe <= 4'h1;
        do0 <= 4'h1;
        #2;
        chk("pad0", 32'({oeb[0], po[0]}), 32'h1);
        @(posedge clk);
        do1 <= 4'h2;
        oe <= 4'h3;
        ce <= 4'hf;
        #2;
        chk("oeb1", 32'(oeb[1]), 32'h1);
        tick_o();
        chk("pad1", 32'({oeb[1], po[1]}), 32'h1);
        @(posedge clk);
        ce <= 4'h0;
        do1 <= 4'h0;
        tick_o();
        chk("po1", 32'(po[1]), 32'h1);
        @(posedge clk);
        ce <= 4'hf;
        oe <= 4'h0;
        tick_o();
        chk("oeb", 32'(oeb), 32'hf);
        $display("t_out done");
    endtask

    task automatic t_in();
        @(posedge clk);
        itk <= 4'h2;
        @(posedge clk);
        lvl <= 4'h5;
        @(posedge clk);
        itk <= 4'h0;
        #2;
        chk("in1", 32'({d1[1], d0[1]}), 32'h2);
        chk("in0", 32'({d1[0], d0[0]}), 32'h3);
        @(posedge clk);
        ce <= 4'h0;
        lvl <= 4'h7;
        itk <= 4'h2;
        @(posedge clk);
        itk <= 4'h0;
        ce <= 4'hf;
        #2;
        chk("in1", 32'(d0[1]), 32'h0);
        $display("t_in done");
    endtask

    task automatic t_hold();
        @(posedge clk);
        hold <= 4'h1;
        @(posedge clk);
        lvl <= 4'h6;
        #2;
        chk("held", 32'(d0[0]), 32'h1);
        @(posedge clk);
        hold <= 4'h0;
        #2;
        chk("live", 32'(d0[0]), 32'h0);
        $display("t_hold done");
    endtask

    task automatic t_frz();
        wr_reg(8'h00, 32'h003);
        @(posedge clk);
        lvl <= 4'h3;
        #2;
        chk("frz", 32'({d0[2], d0[0]}), 32'h3);
        rd_reg(8'h04, 32'h505);
        wr_reg(8'h00, 32'h002);
        chk("thaw", 32'(d0[2]), 32'h0);
        $display("t_frz done");
    endtask

    task automatic t_pull();
        int k;
        chk("blk", 32'(blk), 32'h8);
        chk("pen", 32'(pen), 32'h4);
        for (k = 0; k < 4; k++)
        begin
            wr_reg(8'h18, 32'h031 | (k << 6));
            chk("psel", 32'(psel[5:4]), 32'(k));
        end
        wr_reg(8'h00, 32'h000);
        @(posedge clk);
        #2;
        chk("float", 32'({act, oeb}), 32'h0f);
        $display("t_pull done");
    endtask

    // Power-on reset during a fresh download must restore the default pad settings
    task automatic t_rst();
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        #2;
        chk("rst", 32'({act, pen, oeb}), 32'h0ff);
        rd_reg(8'h18, 32'h0e0);
        $display("t_rst done");
    endtask

    initial
    begin
        {rst_b, wr, rd} = 3'h0;
        {itk, otk, ce, oe, hold, do0, do1} = 28'h0;
        addr = 8'h00;
        wdata = 32'h0;
        drv = 4'h7;
        lvl = 4'h7;
        n_mismatch = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_pre();
        t_out();
        t_in();
        t_hold();
        t_frz();
        t_pull();
        t_rst();
        finish_test();
    end
endmodule // tb_top

bind ppc_pad_bank ppc_bank_sva #(.N_PADS(N_PADS)) u_sva (
    .sys_clk_in, .rst_b_in, .reg_wdata_in, .reg_wr_in, .ce_in, .hold_in,
    .din0_out, .pad_i_in, .pad_oe_b_out, .pull_en_out, .pull_sel_out,
    .in_block_out, .active_out);
